// ### hpdf_dma_model.sv
`timescale 1ns/1ps
module hpdf_dma_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_req,
  input  wire logic        i_full,
  input  wire logic [15:0] i_pend,
  output logic      [15:0] o_pend = 16'h0000,
  output logic             o_wr   = 1'b0,
  output logic      [31:0] o_data = 32'h00000000,
  output logic             o_eof  = 1'b0
);
  // ----
  // Host memory refill, four dwords a frame
  // ----
  logic [2:0] left_r = 3'h0;
  always_ff @(posedge i_core_clk) begin
    o_pend <= i_pend;
    o_wr   <= 1'b0;
    o_eof  <= 1'b0;
    o_data <= ~o_data; // Idle data toggles so stale values never match
    // Writes are paced by the full flag, keeping the offered load bounded
    if (left_r != 3'h0 && !i_full) begin
      o_wr   <= 1'b1;
      o_data <= 32'h03020100 + 32'h04040404 * 32'(3'h4 - left_r);
      o_eof  <= (left_r == 3'h1);
      left_r <= left_r - 3'h1;
    end else if (i_req && left_r == 3'h0 && !o_wr) begin
      left_r <= 3'h4;
    end
  end
endmodule

// ### hpdf_mem.sv
`timescale 1ns/1ps
module hpdf_mem #(
  parameter int DW = 32,
  parameter int AW = 4
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_ce,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [2**AW];

  // Registered read keeps the array inferable as block memory
  always_ff @(posedge i_core_clk) begin
    if (i_ce) begin
      if (i_we) begin
        mem[i_waddr] <= i_wdata;
      end
      // Write-through on a same-address hit so a just-written dword is never read stale
      if (i_we && i_waddr == i_raddr) begin
        o_rdata <= i_wdata;
      end else begin
        o_rdata <= mem[i_raddr];
      end
    end
  end
endmodule

// ### hpdf_pkg.sv
package hpdf_pkg;
  localparam int NUM_PORTS       = 16;
  localparam int NUM_CHAN        = 256;
  localparam int CHAN_W          = 8;
  localparam int FIFO_DEPTH      = 16;
  localparam int FIFO_AW         = 4;
  localparam int BUF_SIZE_W      = 13;
  localparam logic [12:0] BUF_SIZE_MAX = 13'h1FFF;
  localparam int BURST_MAX_DW    = 256;
  localparam logic [8:0] BURST_MAX = 9'h100;
  localparam logic [4:0] DESC_BURST_SHORT = 5'h08;
  localparam logic [4:0] DESC_BURST_LONG  = 5'h10;
  localparam int REG_W           = 16;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [FIFO_AW:0] LWM_RESET = 5'h04;

  typedef enum logic [1:0] {
    HPDF_STORE_LARGE,
    HPDF_STORE_SMALL,
    HPDF_STORE_SMALL_LARGE
  } hpdf_store_t;

  typedef enum logic {
    HPDF_SEL_RR,
    HPDF_SEL_PRIO
  } hpdf_sel_t;
endpackage

// ### hpdf_properties.sv
`timescale 1ns/1ps
module hpdf_properties #(
  parameter int NPORT    = 16,
  parameter int DEPTH_AW = 4
) (
  input wire logic             i_core_clk,
  input wire logic             i_resetn,
  input wire logic             i_ce,
  input wire logic [NPORT-1:0] i_chan_en,
  input wire logic [NPORT-1:0] i_eng_need,
  input wire logic [NPORT-1:0] i_pend_desc,
  input wire logic [NPORT-1:0] o_eng_req,
  input wire logic [NPORT-1:0] o_pend_query,
  input wire logic             o_byte_vld,
  input wire logic [3:0]       o_byte_port,
  input wire logic [7:0]       o_byte_data,
  input wire logic             o_dword_vld,
  input wire logic [31:0]      o_dword_data,
  input wire logic             o_dma_req,
  input wire logic [8:0]       i_burst_req,
  input wire logic [8:0]       o_burst_len,
  input wire logic             i_desc_burst_en,
  input wire logic             i_desc_burst_long,
  input wire logic [4:0]       o_desc_burst,
  input wire logic [31:0]      i_buf_addr,
  input wire logic [31:0]      o_buf_addr,
  input wire logic [15:0]      o_reg_rdata
);
  // ----
  // Checks
  // ----
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_first_byte;
    o_byte_vld && o_byte_data == o_dword_data[7:0];
  endsequence
  a_eng_req_follow: assert property (i_ce |=> o_eng_req == $past(i_chan_en))
    else $error("engine request not following enable");
  a_low_port_first: assert property (o_byte_vld |->
    ($past(i_eng_need) & $past(i_chan_en) & ((1 << o_byte_port) - 1)) == 0)
    else $error("lower port skipped");
  a_query_enabled: assert property (i_ce |=> (o_pend_query & ~$past(i_chan_en)) == 0)
    else $error("query for disabled channel");
  a_dma_needs_pend: assert property ($rose(o_dma_req) |-> $past(|i_pend_desc))
    else $error("refill request without pending data");
  a_burst_clip: assert property (i_ce |=> o_burst_len ==
    ($past(i_burst_req) > 9'h100 ? 9'h100 : $past(i_burst_req))) else $error("burst length");
  a_desc_burst_len: assert property (i_ce |=> o_desc_burst ==
    (!$past(i_desc_burst_en) ? 5'h01 : $past(i_desc_burst_long) ? 5'h10 : 5'h08))
    else $error("descriptor burst");
  a_buf_addr_pass: assert property (i_ce |=> o_buf_addr == $past(i_buf_addr))
    else $error("buffer address");
  a_spare_bits_zero: assert property (o_reg_rdata[7:5] == 3'h0)
    else $error("unassigned bits set");
  a_dword_byte_first: assert property (o_dword_vld |-> s_first_byte)
    else $error("dword not sent low byte first");
endmodule

bind hpdf_top hpdf_properties #(.NPORT(NPORT), .DEPTH_AW(DEPTH_AW)) hpdf_properties_inst (.*);

// ### hpdf_top.sv
`timescale 1ns/1ps
module hpdf_top
  import hpdf_pkg::*;
#(
  parameter int NPORT  = hpdf_pkg::NUM_PORTS,
  parameter int DEPTH_AW = hpdf_pkg::FIFO_AW
) (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_resetn,
  input  wire logic                     i_ce,
  // Transmit engines
  input  wire logic [NPORT-1:0]         i_chan_en,
  output logic      [NPORT-1:0]         o_eng_req,
  input  wire logic [NPORT-1:0]         i_eng_need,
  output logic                          o_byte_vld,
  output logic      [3:0]               o_byte_port,
  output logic      [7:0]               o_byte_data,
  output logic                          o_dword_vld,
  output logic      [31:0]              o_dword_data,
  // Refill side (DMA)
  input  wire logic [NPORT-1:0]         i_pend_desc,
  output logic      [NPORT-1:0]         o_pend_query,
  output logic                          o_dma_req,
  output logic      [3:0]               o_dma_chan,
  input  wire logic                     i_dma_wr,
  input  wire logic [31:0]              i_dma_data,
  input  wire logic                     i_dma_eof,
  output logic                          o_fifo_full,
  // Configuration
  input  wire hpdf_pkg::hpdf_sel_t      i_sel_mode,
  input  wire logic [DEPTH_AW:0]        i_lwm,
  input  wire logic [12:0]              i_large_size,
  input  wire logic [12:0]              i_small_size,
  input  wire hpdf_pkg::hpdf_store_t    i_store_mode,
  input  wire logic                     i_desc_burst_en,
  input  wire logic                     i_desc_burst_long,
  input  wire logic [8:0]               i_burst_req,
  input  wire logic [31:0]              i_buf_addr,
  // Register access
  input  wire logic                     i_reg_sel,
  input  wire logic                     i_reg_we,
  input  wire logic [3:0]               i_reg_be,
  input  wire logic [15:0]              i_reg_wdata,
  output logic      [15:0]              o_reg_rdata,
  output logic      [12:0]              o_rx_buf_len,
  output logic      [4:0]               o_desc_burst,
  output logic      [8:0]               o_burst_len,
  output logic      [31:0]              o_buf_addr
);
  import hpdf_pkg::*;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Lowest set bit wins; used for port service and channel priority
  function automatic logic [3:0] low_idx(input logic [NPORT-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = NPORT - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Engine requests and byte servicing
  // ------------------------------------------------------------
  logic [NPORT-1:0] need;
  logic [DEPTH_AW:0] level_r;
  logic              drain_ok_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_eng_req <= '0;
    end else if (i_ce) begin
      o_eng_req <= i_chan_en;
    end
  end

  assign need = i_eng_need & i_chan_en;

  // ------------------------------------------------------------
  // Shared transmit FIFO
  // ------------------------------------------------------------
  logic [DEPTH_AW-1:0] wptr_r;
  logic [DEPTH_AW-1:0] rptr_r;
  logic [1:0]          bsel_r;
  logic [31:0]         rdata;
  logic                wr_ok;
  logic                rd_dw;
  logic                full;
  logic                empty;
  logic [DEPTH_AW-1:0] raddr;

  assign full  = level_r == (DEPTH_AW+1)'(2**DEPTH_AW);
  assign empty = level_r == '0;
  assign wr_ok = i_dma_wr && !full;
  assign rd_dw = drain_ok_r && !empty && (|need) && bsel_r == 2'h3;
  // Look one dword ahead on the last byte, so the registered read is ready for byte 0
  assign raddr = rd_dw ? rptr_r + 1'b1 : rptr_r;

  hpdf_mem #(.DW(32), .AW(DEPTH_AW)) u_mem (
    .i_core_clk (i_core_clk),
    .i_ce       (i_ce),
    .i_we       (wr_ok),
    .i_waddr    (wptr_r),
    .i_wdata    (i_dma_data),
    .i_raddr    (raddr),
    .o_rdata    (rdata)
  );

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      level_r <= '0;
    end else if (i_ce) begin
      if (wr_ok) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (rd_dw) begin
        rptr_r <= rptr_r + 1'b1;
      end
      level_r <= level_r + (DEPTH_AW+1)'(wr_ok) - (DEPTH_AW+1)'(rd_dw);
    end
  end

  // Drain is held off until the refill passes the mark or ends a frame
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      drain_ok_r <= 1'b0;
    end else if (i_ce) begin
      if (level_r > i_lwm || (wr_ok && i_dma_eof)) begin
        drain_ok_r <= 1'b1;
      end else if (empty) begin
        drain_ok_r <= 1'b0;
      end
    end
  end

  // Bytes out to the highest-priority port, four per dword
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      bsel_r      <= '0;
      o_byte_vld  <= 1'b0;
      o_byte_port <= '0;
      o_byte_data <= '0;
      o_dword_vld <= 1'b0;
      o_dword_data <= '0;
    end else if (i_ce) begin
      o_byte_vld  <= 1'b0;
      o_dword_vld <= 1'b0;
      if (drain_ok_r && !empty && (|need)) begin
        o_byte_vld  <= 1'b1;
        o_byte_port <= low_idx(need);
        o_byte_data <= rdata[8*bsel_r +: 8];
        bsel_r      <= bsel_r + 1'b1;
        if (bsel_r == 2'h0) begin
          o_dword_vld  <= 1'b1;
          o_dword_data <= rdata;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Refill requests and channel selection
  // ------------------------------------------------------------
  logic [NPORT-1:0] low;
  logic [NPORT-1:0] cand;
  logic [3:0]       rr_last_r;
  logic [3:0]       pick;
  logic [NPORT-1:0] rot;

  assign low  = {NPORT{level_r <= i_lwm}} & i_chan_en;
  assign cand = low & i_pend_desc;

  always_comb begin
    rot  = (cand >> (rr_last_r + 1'b1)) | (cand << (NPORT - 1 - rr_last_r));
    pick = (i_sel_mode == HPDF_SEL_PRIO) ? low_idx(cand)
         : 4'(low_idx(rot) + rr_last_r + 1'b1);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_pend_query <= '0;
      o_dma_req    <= 1'b0;
      o_dma_chan   <= '0;
      rr_last_r    <= 4'hF;
    end else if (i_ce) begin
      o_pend_query <= low;
      o_dma_req    <= |cand;
      if (|cand) begin
        o_dma_chan <= pick;
        rr_last_r  <= pick;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_fifo_full <= 1'b0;
    end else if (i_ce) begin
      o_fifo_full <= full;
    end
  end

  // ------------------------------------------------------------
  // DMA options
  // ------------------------------------------------------------
  logic first_buf_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_rx_buf_len <= '0;
      o_desc_burst <= 5'h01;
      o_burst_len  <= '0;
      o_buf_addr   <= '0;
      first_buf_r  <= 1'b1;
    end else if (i_ce) begin
      o_buf_addr <= i_buf_addr;
      unique case (i_store_mode)
        HPDF_STORE_SMALL:       o_rx_buf_len <= i_small_size;
        HPDF_STORE_SMALL_LARGE: o_rx_buf_len <= first_buf_r ? i_small_size : i_large_size;
        default:                o_rx_buf_len <= i_large_size;
      endcase
      if (i_dma_wr) begin
        first_buf_r <= i_dma_eof;
      end
      o_desc_burst <= !i_desc_burst_en ? 5'h01
                    : (i_desc_burst_long ? DESC_BURST_LONG : DESC_BURST_SHORT);
      o_burst_len  <= (i_burst_req > BURST_MAX) ? BURST_MAX : i_burst_req;
    end
  end

  // ------------------------------------------------------------
  // Configuration register
  // ------------------------------------------------------------
  logic [15:0] cfg_r;

  // Any byte enable commits the full 16-bit word; none means no access
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      cfg_r       <= REG_RESET;
      o_reg_rdata <= '0;
    end else if (i_ce && i_reg_sel && (|i_reg_be)) begin
      if (i_reg_we) begin
        cfg_r <= i_reg_wdata;
      end
      o_reg_rdata <= {cfg_r[15:8], 3'h0, level_r};
    end
  end
endmodule

// ### test_hdlc_packet_dma_fifo_flow.sv
`timescale 1ns/1ps
module test_hdlc_packet_dma_fifo_flow;
  import hpdf_pkg::*;
  logic        i_core_clk = 1'b0, i_resetn = 1'b0, sel_r = 1'b0, we = 1'b0;
  logic        de = 1'b0, dl = 1'b0, bv, dv, rq, wr, eof, full;
  logic [15:0] ch = 16'h0, nd = 16'h0, hp = 16'h0, er, pq, pd, wd = 16'h0, rd;
  logic [31:0] ba = 32'h0, bo, dd;
  logic [12:0] lg = 13'h0, sm = 13'h0, rl;
  logic [8:0]  br = 9'h0, bl;
  logic [7:0]  bd;
  logic [4:0]  db;
  logic [3:0]  be = 4'h0, bp, dc;
  logic        ce = 1'b1;
  hpdf_store_t st = HPDF_STORE_LARGE;
  int          err_count = 0, comparisons = 0;
  always #50 i_core_clk = ~i_core_clk;
  hpdf_top hpdf_top_inst (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(ce),
    .i_chan_en(ch), .o_eng_req(er), .i_eng_need(nd), .o_byte_vld(bv), .o_byte_port(bp),
    .o_byte_data(bd), .o_dword_vld(dv), .o_dword_data(), .i_pend_desc(pd),
    .o_pend_query(pq), .o_dma_req(rq), .o_dma_chan(dc), .i_dma_wr(wr), .i_dma_data(dd),
    .i_dma_eof(eof), .o_fifo_full(full), .i_sel_mode(hpdf_sel_t'(de)), .i_lwm(5'h01),
    .i_large_size(lg), .i_small_size(sm), .i_store_mode(st), .i_desc_burst_en(de),
    .i_desc_burst_long(dl), .i_burst_req(br), .i_buf_addr(ba), .i_reg_sel(sel_r),
    .i_reg_we(we), .i_reg_be(be), .i_reg_wdata(wd), .o_reg_rdata(rd), .o_rx_buf_len(rl),
    .o_desc_burst(db), .o_burst_len(bl), .o_buf_addr(bo));
  hpdf_dma_model hpdf_dma_model_inst (.i_core_clk(i_core_clk), .i_req(rq), .i_full(full),
    .i_pend(hp), .o_pend(pd), .o_wr(wr), .o_data(dd), .o_eof(eof));
  // ----
  // Helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask
  // Bounded wait for the next byte pulse
  task automatic wait_byte;
    int n;
    n = 0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while (bv !== 1'b1 && n < 60);
    if (bv !== 1'b1) begin
      err_count++;
      give_verdict;
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_config;
    logic [8:0] tab [4] = '{9'h000, 9'h100, 9'h101, 9'h1FF};
    for (int k = 0; k < 4; k++) begin
      @(posedge i_core_clk);
      br <= tab[k];
      de <= k[0];
      dl <= k[1];
      ba <= 32'h80000001 << k;
      lg <= 13'h1FFF;
      sm <= 13'h0010;
      st <= hpdf_store_t'(k % 3);
      step(2);
      chk(bl, k < 2 ? tab[k] : 9'h100);
      chk(db, !k[0] ? 5'h01 : k[1] ? 5'h10 : 5'h08);
      chk(bo, 32'h80000001 << k);
      if (k < 3) chk(rl, k == 0 ? 13'h1FFF : 13'h0010);
    end
  endtask
  task automatic t_regs;
    @(posedge i_core_clk);
    sel_r <= 1'b1;
    we <= 1'b1;
    wd <= 16'hA500;
    step(3);
    chk(rd[15:8], 8'h00);
    @(posedge i_core_clk);
    be <= 4'h4;
    step(3);
    chk(rd[15:8], 8'hA5);
    chk(rd[7:5], 3'h0);
    @(posedge i_core_clk);
    sel_r <= 1'b0;
    we <= 1'b0;
    be <= 4'h0;
  endtask
  // Clock enable low must freeze the engine request register
  task automatic t_hold;
    @(posedge i_core_clk);
    ce <= 1'b0;
    ch <= 16'h0001;
    step(2);
    chk(er, 16'h0000);
    @(posedge i_core_clk);
    ce <= 1'b1;
    ch <= 16'h0000;
    step(1);
  endtask
  // Ports 3 and 5 both need bytes; only channel 3 has data pending, and port 3, the lower, is served
  task automatic t_tx;
    @(posedge i_core_clk);
    ch <= 16'h0028;
    nd <= 16'h0028;
    hp <= 16'h0008;
    step(1);
    chk(er, 16'h0028);
    chk(pq & 16'h0028, 16'h0028);
    step(1);
    chk(dc, 4'h3);
    for (int b = 0; b < 8; b++) begin
      wait_byte;
      chk(bd, b);
      chk(bp, 4'h3);
    end
  endtask
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    t_config;
    t_regs;
    t_hold;
    t_tx;
    give_verdict;
  end
endmodule
